// *** stc_regs.svh ***
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
`define STC_CLK_MHZ          50
// times in their printed units
`define STC_STUCK_MIN_MS     24
`define STC_STUCK_MAX_MS     39
`define STC_ADC_SETTLE_US    304
`define STC_SYNC_ABORT_MS    255
`define STC_HOLD_TRACK_MS    32
`define STC_SETUP_TRACK_MS   32
`define STC_DEC_TRACK_US     88
`define STC_GPIO_OUT_NS      2500
`define STC_SPIKE_NS         98
// derived cycle counts
`define STC_STUCK_CYC        (`STC_STUCK_MIN_MS * 1000 * `STC_CLK_MHZ)
`define STC_ADC_SETTLE_CYC   (`STC_ADC_SETTLE_US * `STC_CLK_MHZ)
`define STC_SYNC_ABORT_CYC   (`STC_SYNC_ABORT_MS * 1000 * `STC_CLK_MHZ)
`define STC_HOLD_TRACK_CYC   (`STC_HOLD_TRACK_MS * 1000 * `STC_CLK_MHZ)
`define STC_SETUP_TRACK_CYC  (`STC_SETUP_TRACK_MS * 1000 * `STC_CLK_MHZ)
`define STC_DEC_TRACK_CYC    (`STC_DEC_TRACK_US * `STC_CLK_MHZ)
`define STC_SPIKE_CYC        ((`STC_SPIKE_NS * `STC_CLK_MHZ + 999) / 1000)
`define STC_SAMPLE_EDGE      26
`define STC_UPDATE_EDGE      35
`define STC_DELAY_W          10
`endif

// *** stc_pkg.sv ***
package stc_pkg;
   typedef enum logic [2:0] {
      STC_TRK_IDLE  = 3'b000,
      STC_TRK_SYNC  = 3'b001,
      STC_TRK_HOLD  = 3'b010,
      STC_TRK_SETUP = 3'b011,
      STC_TRK_RAMP  = 3'b100
   } stc_trk_state_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } stc_bus_t;
   typedef struct packed {
      logic gpio1;
      logic gpio0;
   } stc_gpio_t;
endpackage

// *** stc_glitch_filter.sv ***
`timescale 1ns/1ps
// passes a level only after it holds for more than CYC cycles
module stc_glitch_filter #(
   parameter int CYC = 5
) (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic din,
   output logic      dout
);
   initial begin
      if (CYC < 1 || CYC > 255) $error("stc_glitch_filter: CYC must be 1 to 255");
   end
   logic       s1_ff;
   logic       s2_ff;
   logic [7:0] cnt_ff;
   logic       out_ff;
   assign dout = out_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cnt_ff <= 8'h00;
         out_ff <= 1'b1;
      end else if (s2_ff == out_ff) begin
         cnt_ff <= 8'h00;
      end else if (cnt_ff >= 8'(CYC)) begin
         out_ff <= s2_ff;
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule

// *** stc_timing_ctrl.sv ***
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_timing_ctrl #(
   parameter int STUCK_CYC       = `STC_STUCK_CYC,
   parameter int SYNC_ABORT_CYC  = `STC_SYNC_ABORT_CYC,
   parameter int HOLD_TRACK_CYC  = `STC_HOLD_TRACK_CYC,
   parameter int SETUP_TRACK_CYC = `STC_SETUP_TRACK_CYC,
   parameter int ADC_SETTLE_CYC  = `STC_ADC_SETTLE_CYC,
   parameter int DEC_TRACK_CYC   = `STC_DEC_TRACK_CYC
) (
   input  wire logic                     mclk,
   input  wire logic                     resetn,
   input  wire stc_pkg::stc_bus_t        bus_in,
   input  wire logic                     cmd_done,
   input  wire logic                     pin_read_cmd,
   input  wire logic                     pin_write_cmd,
   input  wire stc_pkg::stc_gpio_t       pin_write_val,
   input  wire stc_pkg::stc_gpio_t       gpio_in,
   input  wire logic                     gpio_cfg_in,
   input  wire logic                     adc_chan_change,
   input  wire logic                     sync_cmd,
   input  wire logic                     track_on_cmd,
   input  wire logic                     track_off_cmd,
   input  wire logic [`STC_DELAY_W-1:0]  track_delay_init,
   output logic                          bus_abort,
   output logic                          sda_release,
   output logic                          adc_start_ok,
   output stc_pkg::stc_gpio_t            gpio_read_val,
   output stc_pkg::stc_gpio_t            gpio_oe,
   output logic                          gpio_cfg_oe,
   output logic                          trim_current_dac_connected,
   output logic [`STC_DELAY_W-1:0]       channel_track_delay_count,
   output logic                          sync_pending,
   output logic [5:0]                    scl_edge_count
);
   initial begin
      if (STUCK_CYC < 1 || SYNC_ABORT_CYC < 1 || HOLD_TRACK_CYC < 1 ||
          SETUP_TRACK_CYC < 1 || ADC_SETTLE_CYC < 1 || DEC_TRACK_CYC < 1)
         $error("stc_timing_ctrl: counts must be at least 1");
      if (STUCK_CYC >= 2**31 - 1) $error("stc_timing_ctrl: count too large");
      if (ADC_SETTLE_CYC > 65535 || DEC_TRACK_CYC > 65536)
         $error("stc_timing_ctrl: settle or step count exceeds its 16-bit counter");
   end

   logic scl_f;
   logic sda_f;
   stc_glitch_filter #(.CYC(`STC_SPIKE_CYC)) u_scl_flt (
      .mclk   (mclk),
      .resetn (resetn),
      .din    (bus_in.scl),
      .dout   (scl_f)
   );
   stc_glitch_filter #(.CYC(`STC_SPIKE_CYC)) u_sda_flt (
      .mclk   (mclk),
      .resetn (resetn),
      .din    (bus_in.sda),
      .dout   (sda_f)
   );

   logic scl_d_ff;
   logic sda_d_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_f;
         sda_d_ff <= sda_f;
      end
   end
   wire scl_rise = scl_f & ~scl_d_ff;
   wire start_c  = scl_f & scl_d_ff & sda_d_ff & ~sda_f;
   wire stop_c   = scl_f & scl_d_ff & ~sda_d_ff & sda_f;

   // transaction activity and edge counter
   logic        active_ff;
   logic [31:0] stuck_cnt_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         active_ff      <= 1'b0;
         scl_edge_count <= 6'h00;
      end else if (start_c) begin
         active_ff      <= 1'b1;
         scl_edge_count <= 6'h00;
      end else if (stop_c || cmd_done || bus_abort) begin
         active_ff      <= 1'b0;
      end else if (active_ff && scl_rise && scl_edge_count != 6'h3f) begin
         scl_edge_count <= scl_edge_count + 6'h01;
      end
   end

   // stuck bus timer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         stuck_cnt_ff <= 32'h0;
         bus_abort    <= 1'b0;
         sda_release  <= 1'b0;
      end else begin
         bus_abort   <= 1'b0;
         sda_release <= 1'b0;
         if (!active_ff || start_c) begin
            stuck_cnt_ff <= 32'h0;
         end else if (stuck_cnt_ff == 32'(STUCK_CYC - 1)) begin
            stuck_cnt_ff <= 32'h0;
            bus_abort    <= 1'b1;
            sda_release  <= 1'b1;
         end else begin
            stuck_cnt_ff <= stuck_cnt_ff + 32'h1;
         end
      end
   end

   // pin read sample and pin write update
   wire at_edge26 = active_ff && scl_rise && scl_edge_count == 6'(`STC_SAMPLE_EDGE - 1);
   wire at_edge35 = active_ff && scl_rise && scl_edge_count == 6'(`STC_UPDATE_EDGE - 1);
   logic cfg_seen_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         gpio_read_val <= '0;
      end else if (at_edge26 && pin_read_cmd) begin
         gpio_read_val <= gpio_in;
      end
   end
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         gpio_oe     <= '0;
         cfg_seen_ff <= 1'b0;
      end else if (!cfg_seen_ff) begin
         cfg_seen_ff <= 1'b1;
         gpio_oe     <= gpio_cfg_in ? 2'b11 : 2'b00;
      end else if (at_edge35 && pin_write_cmd) begin
         gpio_oe.gpio0 <= ~pin_write_val.gpio0;
         gpio_oe.gpio1 <= ~pin_write_val.gpio1;
      end
   end

   // adc settle
   logic [15:0] settle_cnt_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         settle_cnt_ff <= 16'h0;
         adc_start_ok  <= 1'b0;
      end else if (adc_chan_change) begin
         settle_cnt_ff <= 16'(ADC_SETTLE_CYC);
         adc_start_ok  <= 1'b0;
      end else if (settle_cnt_ff > 16'h1) begin
         settle_cnt_ff <= settle_cnt_ff - 16'h1;
      end else begin
         settle_cnt_ff <= 16'h0;
         adc_start_ok  <= 1'b1;
      end
   end

   // tracking sequencer
   stc_pkg::stc_trk_state_t state_ff;
   logic [31:0] tcnt_ff;
   logic [15:0] tick_ff;
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_ff                   <= stc_pkg::STC_TRK_IDLE;
         tcnt_ff                    <= 32'h0;
         tick_ff                    <= 16'h0;
         sync_pending               <= 1'b0;
         gpio_cfg_oe                <= 1'b0;
         trim_current_dac_connected <= 1'b1;
         channel_track_delay_count  <= '0;
      end else begin
         unique case (state_ff)
            stc_pkg::STC_TRK_IDLE: begin
               tcnt_ff <= 32'h0;
               if (sync_cmd) begin
                  state_ff     <= stc_pkg::STC_TRK_SYNC;
                  sync_pending <= 1'b1;
               end
            end
            stc_pkg::STC_TRK_SYNC: begin
               if (track_on_cmd || track_off_cmd) begin
                  sync_pending <= 1'b0;
                  tcnt_ff      <= 32'h0;
                  gpio_cfg_oe  <= track_on_cmd;
                  channel_track_delay_count <= track_delay_init;
                  state_ff <= track_on_cmd ? stc_pkg::STC_TRK_HOLD
                                           : stc_pkg::STC_TRK_SETUP;
               end else if (tcnt_ff == 32'(SYNC_ABORT_CYC - 1)) begin
                  sync_pending <= 1'b0;
                  state_ff     <= stc_pkg::STC_TRK_IDLE;
               end else begin
                  tcnt_ff <= tcnt_ff + 32'h1;
               end
            end
            stc_pkg::STC_TRK_HOLD: begin
               if (tcnt_ff == 32'(HOLD_TRACK_CYC - 1)) begin
                  trim_current_dac_connected <= 1'b0;
                  state_ff <= stc_pkg::STC_TRK_IDLE;
               end else begin
                  tcnt_ff <= tcnt_ff + 32'h1;
               end
            end
            stc_pkg::STC_TRK_SETUP: begin
               if (tcnt_ff == 32'(SETUP_TRACK_CYC - 1)) begin
                  tick_ff  <= 16'h0;
                  state_ff <= stc_pkg::STC_TRK_RAMP;
               end else begin
                  tcnt_ff <= tcnt_ff + 32'h1;
               end
            end
            stc_pkg::STC_TRK_RAMP: begin
               if (channel_track_delay_count == '0) begin
                  state_ff <= stc_pkg::STC_TRK_IDLE;
               end else if (tick_ff == 16'(DEC_TRACK_CYC - 1)) begin
                  tick_ff <= 16'h0;
                  channel_track_delay_count <= channel_track_delay_count - 10'h001;
               end else begin
                  tick_ff <= tick_ff + 16'h1;
               end
            end
            default: state_ff <= stc_pkg::STC_TRK_IDLE;
         endcase
      end
   end

   chk_stuck_abort: assert property (@(posedge mclk) disable iff (!resetn)
      active_ff && !start_c && stuck_cnt_ff == 32'(STUCK_CYC - 1) |=> bus_abort)
      else $error("stuck timeout did not abort");
   chk_edge_reset: assert property (@(posedge mclk) disable iff (!resetn)
      start_c |=> scl_edge_count == 6'h00)
      else $error("edge count not cleared at start");
   chk_pin_update: assert property (@(posedge mclk) disable iff (!resetn)
      cfg_seen_ff && at_edge35 && pin_write_cmd |=> gpio_oe == ~$past(pin_write_val))
      else $error("pin write not applied");
   chk_pin_sample: assert property (@(posedge mclk) disable iff (!resetn)
      at_edge26 && pin_read_cmd |=> gpio_read_val == $past(gpio_in))
      else $error("pin read not sampled");
   chk_adc_settle: assert property (@(posedge mclk) disable iff (!resetn)
      adc_chan_change |=> !adc_start_ok [*2])
      else $error("adc started without settling");
   chk_sync_abort: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == stc_pkg::STC_TRK_SYNC && !track_on_cmd && !track_off_cmd &&
      tcnt_ff == 32'(SYNC_ABORT_CYC - 1) |=> !sync_pending)
      else $error("sync not aborted");
   chk_dac_hold: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == stc_pkg::STC_TRK_HOLD |-> trim_current_dac_connected)
      else $error("dac disconnected early");
   chk_no_ramp_early: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == stc_pkg::STC_TRK_SETUP |=> $stable(channel_track_delay_count))
      else $error("delay changed during setup wait");
   chk_ramp_step: assert property (@(posedge mclk) disable iff (!resetn)
      state_ff == stc_pkg::STC_TRK_RAMP && channel_track_delay_count != '0 &&
      tick_ff == 16'(DEC_TRACK_CYC - 1)
      |=> channel_track_delay_count == $past(channel_track_delay_count) - 10'h001)
      else $error("ramp step wrong");
   chk_cfg_reset: assert property (@(posedge mclk) disable iff (!resetn)
      !cfg_seen_ff |=> gpio_oe == {2{$past(gpio_cfg_in)}})
      else $error("config default not applied");
   cov_abort:  cover property (@(posedge mclk) bus_abort);
   cov_write:  cover property (@(posedge mclk) at_edge35 && pin_write_cmd);
   cov_ramp:   cover property (@(posedge mclk) state_ff == stc_pkg::STC_TRK_RAMP);
   cov_disc:   cover property (@(posedge mclk) $fell(trim_current_dac_connected));
endmodule

// *** stc_host_model.sv ***
`timescale 1ns/1ps
// bus controller on the far side; both lines idle high through their pull-ups
module stc_host_model (
   input  wire logic         mclk,
   output stc_pkg::stc_bus_t bus
);
   initial bus = 2'b11;

   task automatic hold(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic start();
      bus.sda = 1'b0;
      hold(35);
   endtask

   // data moves only while the clock is low, so no false start or stop
   task automatic clocks(input int n);
      for (int i = 0; i < n; i++) begin
         bus.scl = 1'b0;
         hold(10);
         bus.sda = i[0];
         hold(60);
         bus.scl = 1'b1;
         hold(35);
      end
   endtask

   // 80 ns high spike inside a low phase
   task automatic glitch();
      bus.scl = 1'b0;
      hold(30);
      bus.scl = 1'b1;
      hold(4);
      bus.scl = 1'b0;
      hold(30);
   endtask

   task automatic stop();
      bus.scl = 1'b0;
      bus.sda = 1'b0;
      hold(35);
      bus.scl = 1'b1;
      hold(35);
      bus.sda = 1'b1;
      hold(70);
   endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`include "stc_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
   $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module testbench;
   logic                      mclk = 1'b0;
   logic                      resetn = 1'b0;
   logic                      cmd_done, pin_read_cmd, pin_write_cmd;
   logic                      gpio_cfg_in, adc_chan_change, sync_cmd;
   logic                      track_on_cmd, track_off_cmd;
   logic [`STC_DELAY_W-1:0]   track_delay_init;
   stc_pkg::stc_gpio_t        pin_write_val, gpio_in;
   stc_pkg::stc_bus_t         bus;
   logic                      bus_abort, sda_release, adc_start_ok, gpio_cfg_oe;
   logic                      trim_current_dac_connected, sync_pending;
   stc_pkg::stc_gpio_t        gpio_read_val, gpio_oe;
   logic [`STC_DELAY_W-1:0]   channel_track_delay_count;
   logic [5:0]                scl_edge_count;
   int                        error_cnt = 0, checks_done = 0, n;

   always #10 mclk = ~mclk;

   stc_host_model i_stc_host_model (.mclk(mclk), .bus(bus));

   stc_timing_ctrl #(.STUCK_CYC(6000), .SYNC_ABORT_CYC(300), .HOLD_TRACK_CYC(100),
      .SETUP_TRACK_CYC(100), .ADC_SETTLE_CYC(50), .DEC_TRACK_CYC(10)) i_stc_timing_ctrl (
      .mclk(mclk), .resetn(resetn), .bus_in(bus), .cmd_done(cmd_done),
      .pin_read_cmd(pin_read_cmd), .pin_write_cmd(pin_write_cmd),
      .pin_write_val(pin_write_val), .gpio_in(gpio_in), .gpio_cfg_in(gpio_cfg_in),
      .adc_chan_change(adc_chan_change), .sync_cmd(sync_cmd), .track_on_cmd(track_on_cmd),
      .track_off_cmd(track_off_cmd), .track_delay_init(track_delay_init),
      .bus_abort(bus_abort), .sda_release(sda_release), .adc_start_ok(adc_start_ok),
      .gpio_read_val(gpio_read_val), .gpio_oe(gpio_oe), .gpio_cfg_oe(gpio_cfg_oe),
      .trim_current_dac_connected(trim_current_dac_connected),
      .channel_track_delay_count(channel_track_delay_count),
      .sync_pending(sync_pending), .scl_edge_count(scl_edge_count));

   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic sel(input int w);
      case (w)
         0: return bus_abort;
         1: return adc_start_ok;
         2: return sync_pending;
         3: return trim_current_dac_connected;
         4: return channel_track_delay_count !== 10'h005;
         default: return channel_track_delay_count === 10'h000;
      endcase
   endfunction

   task automatic wt(input int w, input logic v, input int lim, output int cnt);
      cnt = 0;
      while (sel(w) !== v) begin
         @(negedge mclk);
         cnt++;
         if (cnt > lim) begin
            error_cnt++;
            $display("Error at %0t: wait %0d timed out", $time, w);
            finish_test();
         end
      end
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
   endtask

   task automatic t_reset(input logic cfg);
      resetn = 1'b0;
      gpio_cfg_in = cfg;
      repeat (6) @(negedge mclk);
      `CHK(trim_current_dac_connected, 1'b1)
      resetn = 1'b1;
      repeat (2) @(negedge mclk);
      `CHK(gpio_oe, {2{cfg}})
   endtask

   task automatic t_pins();
      gpio_in = 2'b10;
      pin_read_cmd = 1'b1;
      pin_write_cmd = 1'b1;
      pin_write_val = 2'b01;
      i_stc_host_model.start();
      i_stc_host_model.clocks(20);
      i_stc_host_model.glitch();
      i_stc_host_model.clocks(6);
      repeat (130) @(negedge mclk);
      `CHK(scl_edge_count, 6'd26)
      `CHK(gpio_read_val, 2'b10)
      gpio_in = 2'b01;
      i_stc_host_model.clocks(9);
      repeat (85) @(negedge mclk);
      `CHK(gpio_oe, 2'b10)
      `CHK(scl_edge_count, 6'd35)
      `CHK(gpio_read_val, 2'b10)
      pulse(cmd_done);
      i_stc_host_model.stop();
      pin_read_cmd = 1'b0;
      pin_write_cmd = 1'b0;
   endtask

   // transaction left hanging: abort due between the scaled 24 and 39 ms figures
   task automatic t_stuck();
      i_stc_host_model.start();
      `CHK(scl_edge_count, 6'd0)
      wt(0, 1'b1, 10000, n);
      `CHK(n inside {[5965:9715]}, 1'b1)
      `CHK(sda_release, 1'b1)
      i_stc_host_model.stop();
   endtask

   task automatic t_adc();
      pulse(adc_chan_change);
      `CHK(adc_start_ok, 1'b0)
      wt(1, 1'b1, 100, n);
      `CHK(n inside {[46:52]}, 1'b1)
   endtask

   task automatic t_track();
      pulse(sync_cmd);
      `CHK(sync_pending, 1'b1)
      wt(2, 1'b0, 400, n);
      `CHK(n inside {[294:302]}, 1'b1)
      pulse(sync_cmd);
      track_delay_init = 10'h005;
      pulse(track_on_cmd);
      `CHK(gpio_cfg_oe, 1'b1)
      wt(3, 1'b0, 200, n);
      `CHK(n inside {[95:102]}, 1'b1)
      pulse(sync_cmd);
      pulse(track_off_cmd);
      `CHK(channel_track_delay_count, 10'h005)
      `CHK(gpio_cfg_oe, 1'b0)
      wt(4, 1'b1, 200, n);
      `CHK(n inside {[95:112]}, 1'b1)
      `CHK(channel_track_delay_count, 10'h004)
      wt(5, 1'b1, 100, n);
      `CHK(n inside {[36:42]}, 1'b1)
   endtask

   initial begin
      cmd_done = 1'b0;
      pin_read_cmd = 1'b0;
      pin_write_cmd = 1'b0;
      gpio_cfg_in = 1'b0;
      adc_chan_change = 1'b0;
      sync_cmd = 1'b0;
      track_on_cmd = 1'b0;
      track_off_cmd = 1'b0;
      track_delay_init = 10'h000;
      pin_write_val = 2'b11;
      gpio_in = 2'b11;
      t_reset(1'b0);
      t_reset(1'b1);
      t_pins();
      t_stuck();
      t_adc();
      t_track();
      finish_test();
   end
endmodule
